// ### pkg/scp_pkg.sv
// Constants, types and helpers for the serial configuration and pump control bank
// ==========================================================================
// Overview of operation
// - Readback uses data pin or separate output pin
// - Bit order and address step follow bit 6
// - Soft reset restores defaults, bit self-clears
// - Readback select picks buffered or active copy
// - Bit 7 sets phase detector sense
// - Pump current code: 0.6 to 4.8 mA
// - Antibacklash width code: 2.9, 1.3, 6.0, 2.9 ns
// ==========================================================================
package scp_pkg;

  // ========================================================================
  // Register map
  localparam int unsigned AW = 13;                  // Serial address width
  localparam logic [12:0] OFS_PORT_CFG  = 13'h000;  // serial_port_config
  localparam logic [12:0] OFS_RB_SELECT = 13'h004;  // readback_bank_select
  localparam logic [12:0] OFS_PD_PUMP   = 13'h010;  // phase_detector_pump

  // ========================================================================
  // Field positions
  localparam int unsigned CFG_SEP_OUT_BIT = 7;      // separate_output_enable
  localparam int unsigned CFG_LSB_BIT     = 6;      // LSB first, address up
  localparam int unsigned CFG_SRST_BIT    = 5;      // Self-clearing soft reset
  localparam int unsigned RB_ACTIVE_BIT   = 0;      // Read active copy
  localparam int unsigned PD_SENSE_BIT    = 7;      // phase_detector_sense
  localparam int unsigned PD_CUR_MSB      = 6;      // pump_current_code
  localparam int unsigned PD_CUR_LSB      = 4;
  localparam int unsigned PD_MODE_MSB     = 3;      // pump_force_mode
  localparam int unsigned PD_MODE_LSB     = 2;
  localparam int unsigned PD_ABL_MSB      = 1;      // Antibacklash code
  localparam int unsigned PD_ABL_LSB      = 0;
  localparam int unsigned INSTR_RD_BIT    = 15;     // Read flag of instruction

  // ========================================================================
  // Reset values
  localparam logic       RST_SEP_OUT = 1'b0;
  localparam logic       RST_LSB     = 1'b0;
  localparam logic       RST_RB_ACT  = 1'b0;
  localparam logic [7:0] RST_PD_PUMP = 8'h7c;      // Sense 0, 111, 11, 00

  // ========================================================================
  // Framing constants
  localparam logic [3:0] INSTR_LAST = 4'hf;        // 16-bit instruction
  localparam logic [2:0] BYTE_LAST  = 3'h7;        // 8-bit data bytes

  // ========================================================================
  // Analogue figures carried as numbers for downstream logic
  localparam logic [12:0] PUMP_STEP_UA = 13'h258;  // 600 uA per step
  localparam logic [12:0] ABL_2P9_PS   = 13'hb54;  // 2900 ps
  localparam logic [12:0] ABL_1P3_PS   = 13'h514;  // 1300 ps
  localparam logic [12:0] ABL_6P0_PS   = 13'h1770; // 6000 ps

  // Front-end state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_INSTR = 3'h2,
    ST_DATA  = 3'h4
  } scp_state_t;

  // Next address of a multibyte transfer
  function automatic logic [12:0] scp_step_addr(input logic [12:0] a, input logic up);
    scp_step_addr = up ? a + 13'h1 : a - 13'h1;
  endfunction

  // Pump current in microamps, equal steps from code 000
  function automatic logic [12:0] scp_pump_ua(input logic [2:0] code);
    scp_pump_ua = 13'(PUMP_STEP_UA * ({10'h0, code} + 13'h1));
  endfunction

  // Antibacklash width in picoseconds
  function automatic logic [12:0] scp_abl_ps(input logic [1:0] code);
    unique case (code)
      2'h1:    scp_abl_ps = ABL_1P3_PS;
      2'h2:    scp_abl_ps = ABL_6P0_PS;
      default: scp_abl_ps = ABL_2P9_PS;
    endcase
  endfunction

  // Shift one serial bit into a byte in the chosen order
  function automatic logic [7:0] scp_shift8(input logic [7:0] r, input logic b,
                                            input logic lsb);
    scp_shift8 = lsb ? {b, r[7:1]} : {r[6:0], b};
  endfunction

endpackage

// ### src/scp_bank.sv
// Buffered and active copies of the pump register with registered readback
`timescale 1ns/10ps
`default_nettype none
module scp_bank import scp_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Control
  input  wire logic        soft_rst,
  input  wire logic        update,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [12:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  // Read port
  input  wire logic [12:0] rd_addr,
  input  wire logic        sep_out,
  input  wire logic        lsb_first,
  input  wire logic        rb_active,
  output logic      [7:0]  rd_data_q,
  // Active copy
  output logic      [7:0]  act_q
);

  logic [7:0] buf_q, buf_d;   // Buffered copy, host facing
  logic [7:0] act_d;          // Active copy, drives the pump
  logic [7:0] rd_data_d;      // Readback mux
  logic [7:0] cfg_view;       // Port configuration as read, mirrored

  // ========================================================================
  // Next values
  always_comb begin
    buf_d = buf_q;
    act_d = act_q;
    if (soft_rst) begin
      buf_d = RST_PD_PUMP;
      act_d = RST_PD_PUMP;
    end else begin
      // Update takes the buffer as it stood before a same-cycle write
      if (update) begin
        act_d = buf_q;
      end
      if (wr_en && wr_addr == OFS_PD_PUMP) begin
        buf_d = wr_data;
      end
    end
    // Reset bit always reads back zero since it clears itself
    cfg_view = {sep_out, lsb_first, 4'h0, lsb_first, sep_out};
    unique case (rd_addr)
      OFS_PORT_CFG:  rd_data_d = cfg_view;
      OFS_RB_SELECT: rd_data_d = {7'h0, rb_active};
      OFS_PD_PUMP:   rd_data_d = rb_active ? act_q : buf_q;
      default:       rd_data_d = 8'h00;
    endcase
  end

  // ========================================================================
  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf_q     <= RST_PD_PUMP;
      act_q     <= RST_PD_PUMP;
      rd_data_q <= 8'h00;
    end else begin
      buf_q     <= buf_d;
      act_q     <= act_d;
      rd_data_q <= rd_data_d;
    end
  end

endmodule
`default_nettype wire

// ### src/scp_top.sv
// Serial control port slave with port configuration and pump control registers
`timescale 1ns/10ps
`default_nettype none
module scp_top import scp_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Serial port pins
  input  wire logic        sclk_pin,
  input  wire logic        cs_n_pin,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  // Update strobe pin, copies buffered settings to active
  input  wire logic        update_pin,
  // Port configuration state
  output logic             separate_output_enable,
  output logic             lsb_first,
  // Active pump settings
  output logic             phase_detector_sense,
  output logic      [2:0]  pump_current_code,
  output logic      [1:0]  pump_force_mode,
  output logic      [1:0]  abl_code,
  output logic      [12:0] pump_current_ua,
  output logic      [12:0] abl_width_ps
);

  // ========================================================================
  // Pin synchronisers: first stage feeds only the second
  logic [3:0] sync1_q;        // {update, sdio, cs_n, sclk} first stage
  logic [3:0] sync2_q;        // Second stage, safe to use
  logic [3:0] prev_q;         // Delayed copy for edges

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 4'h2;        // cs_n idles high
      sync2_q <= 4'h2;
      prev_q  <= 4'h2;
    end else begin
      sync1_q <= {update_pin, sdio_in, cs_n_pin, sclk_pin};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  logic sclk_rise;            // Sample point
  logic sclk_fall;            // Launch point for read data
  logic cs_n_s;               // Synchronised chip select
  logic din_s;                // Synchronised data in
  logic upd_rise;             // Update strobe edge
  assign sclk_rise = sync2_q[0] & ~prev_q[0];
  assign sclk_fall = ~sync2_q[0] & prev_q[0];
  assign cs_n_s    = sync2_q[1];
  assign din_s     = sync2_q[2];
  assign upd_rise  = sync2_q[3] & ~prev_q[3];

  // ========================================================================
  // Front-end state
  scp_state_t  st_q, st_d;             // Transfer phase
  logic [3:0]  cnt_q, cnt_d;           // Instruction bit count
  logic [2:0]  idx_q, idx_d;           // Bit index within a data byte
  logic [15:0] instr_q, instr_d;       // Instruction shift register
  logic [7:0]  rx_q, rx_d;             // Write data shift register
  logic [12:0] addr_q, addr_d;         // Current register address
  logic        rd_q, rd_d;             // Transfer is a read
  logic        sep_q, sep_d;           // separate_output_enable
  logic        lsb_q, lsb_d;           // LSB first, address increments
  logic        rbsel_q, rbsel_d;       // Readback select
  logic        bit_q, bit_d;           // Bit launched on the out pins
  logic        sdio_oe_q, sdio_oe_d;   // Data pin drive
  logic        so_oe_q, so_oe_d;       // Separate out pin drive
  logic        wr_en;                  // One-cycle register write
  logic [7:0]  wr_data;                // Byte being written
  logic        srst;                   // One-cycle soft reset
  logic [15:0] instr_sh;               // Instruction after this bit
  logic [7:0]  rd_data;                // Registered readback byte
  logic [7:0]  act;                    // Active pump byte

  // Next-state logic of the serial front end
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    idx_d     = idx_q;
    instr_d   = instr_q;
    rx_d      = rx_q;
    addr_d    = addr_q;
    rd_d      = rd_q;
    sep_d     = sep_q;
    lsb_d     = lsb_q;
    rbsel_d   = rbsel_q;
    bit_d     = bit_q;
    wr_en     = 1'b0;
    wr_data   = scp_shift8(rx_q, din_s, lsb_q);
    srst      = 1'b0;
    // Whole instruction follows the bit order too
    instr_sh  = lsb_q ? {din_s, instr_q[15:1]} : {instr_q[14:0], din_s};
    if (cs_n_s) begin
      // Deselect abandons any partial byte
      st_d = ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          st_d  = ST_INSTR;
          cnt_d = 4'h0;
        end
        ST_INSTR: begin
          if (sclk_rise) begin
            instr_d = instr_sh;
            cnt_d   = cnt_q + 4'h1;
            if (cnt_q == INSTR_LAST) begin
              addr_d = instr_sh[AW-1:0];
              rd_d   = instr_sh[INSTR_RD_BIT];
              idx_d  = 3'h0;
              st_d   = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            idx_d = idx_q + 3'h1;
            if (!rd_q) begin
              rx_d = wr_data;
            end
            if (idx_q == BYTE_LAST) begin
              wr_en  = ~rd_q;
              addr_d = scp_step_addr(addr_q, lsb_q);
            end
          end
          // Readback byte is registered two cycles after the address step, six cycles before the next fall
          if (sclk_fall && rd_q) begin
            bit_d = lsb_q ? rd_data[idx_q] : rd_data[BYTE_LAST - idx_q];
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    // Upper nibble decides; the host keeps the mirror so order never matters
    if (wr_en && addr_q == OFS_PORT_CFG) begin
      sep_d = wr_data[CFG_SEP_OUT_BIT];
      lsb_d = wr_data[CFG_LSB_BIT];
      srst  = wr_data[CFG_SRST_BIT];
    end
    if (wr_en && addr_q == OFS_RB_SELECT) begin
      rbsel_d = wr_data[RB_ACTIVE_BIT];
    end
    // Soft reset is a pulse, so the bit is never stored and self-clears
    if (srst) begin
      sep_d   = RST_SEP_OUT;
      lsb_d   = RST_LSB;
      rbsel_d = RST_RB_ACT;
    end
    // Read data goes out on one pin only, the other floats
    sdio_oe_d = ~cs_n_s && st_q == ST_DATA && rd_q && ~sep_q;
    so_oe_d   = ~cs_n_s && st_q == ST_DATA && rd_q && sep_q;
  end

  // Front-end registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q      <= ST_IDLE;
      cnt_q     <= 4'h0;
      idx_q     <= 3'h0;
      instr_q   <= 16'h0000;
      rx_q      <= 8'h00;
      addr_q    <= 13'h0000;
      rd_q      <= 1'b0;
      sep_q     <= RST_SEP_OUT;
      lsb_q     <= RST_LSB;
      rbsel_q   <= RST_RB_ACT;
      bit_q     <= 1'b0;
      sdio_oe_q <= 1'b0;
      so_oe_q   <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      idx_q     <= idx_d;
      instr_q   <= instr_d;
      rx_q      <= rx_d;
      addr_q    <= addr_d;
      rd_q      <= rd_d;
      sep_q     <= sep_d;
      lsb_q     <= lsb_d;
      rbsel_q   <= rbsel_d;
      bit_q     <= bit_d;
      sdio_oe_q <= sdio_oe_d;
      so_oe_q   <= so_oe_d;
    end
  end

  // ========================================================================
  // Register store: buffered and active copies
  scp_bank scp_bank_inst (
    .clk       (clk),
    .nrst      (nrst),
    .soft_rst  (srst),
    .update    (upd_rise),
    .wr_en     (wr_en),
    .wr_addr   (addr_q),
    .wr_data   (wr_data),
    .rd_addr   (addr_q),
    .sep_out   (sep_q),
    .lsb_first (lsb_q),
    .rb_active (rbsel_q),
    .rd_data_q (rd_data),
    .act_q     (act)
  );

  // ========================================================================
  // Decoded pump figures, registered so every output is a flop
  logic [12:0] ua_q;          // Pump current in microamps
  logic [12:0] ps_q;          // Antibacklash width in picoseconds
  logic [12:0] ua_d;
  logic [12:0] ps_d;

  always_comb begin
    ua_d = scp_pump_ua(act[PD_CUR_MSB:PD_CUR_LSB]);
    ps_d = scp_abl_ps(act[PD_ABL_MSB:PD_ABL_LSB]);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ua_q <= 13'h0000;
      ps_q <= 13'h0000;
    end else begin
      ua_q <= ua_d;
      ps_q <= ps_d;
    end
  end

  // ========================================================================
  // Outputs
  assign sdio_out               = bit_q;
  assign sdio_oe                = sdio_oe_q;
  assign serial_out_pin         = bit_q;
  assign serial_out_oe          = so_oe_q;
  assign separate_output_enable = sep_q;
  assign lsb_first              = lsb_q;
  // 0: higher control voltage raises frequency, 1: lowers it
  assign phase_detector_sense   = act[PD_SENSE_BIT];
  assign pump_current_code      = act[PD_CUR_MSB:PD_CUR_LSB];
  // 00 hi-z, 01 source, 10 sink, 11 normal
  assign pump_force_mode        = act[PD_MODE_MSB:PD_MODE_LSB];
  assign abl_code               = act[PD_ABL_MSB:PD_ABL_LSB];
  assign pump_current_ua        = ua_q;
  assign abl_width_ps           = ps_q;

endmodule
`default_nettype wire

// ### tb/scp_chk.sv
// Port checker for the serial configuration and pump bank
`timescale 1ns/10ps
`default_nettype none
module scp_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Serial pins
  input wire logic        sclk_pin,
  input wire logic        cs_n_pin,
  input wire logic        sdio_in,
  input wire logic        sdio_out,
  input wire logic        sdio_oe,
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe,
  input wire logic        update_pin,
  // Settings
  input wire logic        separate_output_enable,
  input wire logic        lsb_first,
  input wire logic        phase_detector_sense,
  input wire logic [2:0]  pump_current_code,
  input wire logic [1:0]  pump_force_mode,
  input wire logic [1:0]  abl_code,
  input wire logic [12:0] pump_current_ua,
  input wire logic [12:0] abl_width_ps
);
  // ========================================
  // Helper ages
  logic [3:0] upd_q, upd_d; // Cycles since update pin high
  logic [3:0] csh_q, csh_d; // Cycles since select went high
  logic [7:0] act;          // Active byte as one value
  assign act = {phase_detector_sense, pump_current_code, pump_force_mode, abl_code};
  // Saturating ages, so long idle spells never wrap
  always_comb begin
    upd_d = update_pin ? 4'h0 : upd_q + {3'h0, upd_q != 4'hf};
    csh_d = !cs_n_pin ? 4'h0 : csh_q + {3'h0, csh_q != 4'hf};
  end
  // Register ages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upd_q <= 4'hf;
      csh_q <= 4'hf;
    end else begin
      upd_q <= upd_d;
      csh_q <= csh_d;
    end
  end
  // ========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_sep_quiet;
    !separate_output_enable |-> !serial_out_oe;
  endproperty
  a_sep_quiet: assert property (p_sep_quiet) else $error("separate pin driven");
  property p_sep_sdio;
    separate_output_enable |-> !sdio_oe;
  endproperty
  a_sep_sdio: assert property (p_sep_sdio) else $error("data pin driven");
  property p_oe_rise;
    $rose(sdio_oe || serial_out_oe) |-> !cs_n_pin;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive outside frame");
  property p_oe_idle;
    csh_q >= 4'h6 |-> !sdio_oe && !serial_out_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive after frame");
  property p_out_edge;
    $changed(serial_out_pin) && !cs_n_pin |-> !$past(sclk_pin);
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("read bit off edge");
  property p_ua;
    $past(nrst) |-> pump_current_ua == ({10'h0, $past(pump_current_code)} + 13'h1) * 13'h258;
  endproperty
  a_ua: assert property (p_ua) else $error("pump current wrong");
  property p_ps;
    $past(nrst) |-> abl_width_ps == ($past(abl_code) == 2'h1 ? 13'h514 :
                                     $past(abl_code) == 2'h2 ? 13'h1770 : 13'hb54);
  endproperty
  a_ps: assert property (p_ps) else $error("pulse width wrong");
  property p_act_hold;
    $changed(act) |-> upd_q < 4'h8 || act == 8'h7c;
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("active changed");
  c_upd: cover property ($changed(act));
  c_sep: cover property ($rose(serial_out_oe));
  c_sdio: cover property ($rose(sdio_oe));
endmodule
bind scp_top scp_chk scp_chk_inst (.clk, .nrst, .sclk_pin, .cs_n_pin, .sdio_in, .sdio_out,
  .sdio_oe, .serial_out_pin, .serial_out_oe, .update_pin, .separate_output_enable,
  .lsb_first, .phase_detector_sense, .pump_current_code, .pump_force_mode, .abl_code,
  .pump_current_ua, .abl_width_ps);
`default_nettype wire

// ### tb/scp_host.sv
// Serial host model that frames register accesses
`timescale 1ns/10ps
`default_nettype none
module scp_host (
  // Clock
  input  wire logic clk,
  // Device pins
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe,
  output logic      sclk_pin,
  output logic      cs_n_pin,
  output logic      sdio_in
);
  logic hd;    // Host data bit
  logic hoe;   // Host drives data pin
  logic sep_q; // Read from separate pin
  logic bad_q; // Wrong pin was driven
  // Released line shows the inverse, never a stale copy
  assign sdio_in = sdio_oe ? sdio_out : hoe ? hd : ~hd;
  initial begin
    sclk_pin = 1'h0;
    cs_n_pin = 1'h1;
    hd = 1'h0;
    hoe = 1'h1;
    sep_q = 1'h0;
    bad_q = 1'h0;
  end
  // One bit: 8 clocks low, sample at the rise, 8 clocks high
  task automatic bitx(input logic o, output logic i);
    hd = o;
    repeat (8) @(negedge clk);
    i = sep_q ? serial_out_pin : sdio_in;
    if (sep_q ? sdio_oe : serial_out_oe) bad_q = 1;
    sclk_pin = 1;
    repeat (8) @(negedge clk);
    sclk_pin = 0;
  endtask
  // Frame: instruction then n bytes, first byte in the low bits
  task automatic xfer(input logic rd, lsb, sep, input logic [12:0] a, input int n,
                      input logic [31:0] w, output logic [31:0] r);
    logic [15:0] s;
    logic        i;
    r = 32'h0;
    sep_q = sep;
    s = {rd, 2'h0, a};
    if (a == 13'h0 && !rd) w[3:0] = {w[4], w[5], w[6], w[7]};
    cs_n_pin = 0;
    for (int k = 0; k < 16; k++) bitx(lsb ? s[k] : s[15-k], i);
    hoe = !rd;
    for (int k = 0; k < 8 * n; k++) begin
      bitx(w[k/8*8 + (lsb ? k%8 : 7-k%8)], i);
      r[k/8*8 + (lsb ? k%8 : 7-k%8)] = i;
    end
    repeat (8) @(negedge clk);
    cs_n_pin = 1;
    hoe = 1;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### tb/scp_top_tb.sv
// Self-checking bench for the serial configuration and pump bank
`timescale 1ns/10ps
`default_nettype none
module scp_top_tb;
  logic        clk, nrst, update_pin, sclk_pin, cs_n_pin, sdio_in;
  logic        sdio_out, sdio_oe, serial_out_pin, serial_out_oe;
  logic        separate_output_enable, lsb_first, phase_detector_sense;
  logic [2:0]  pump_current_code;
  logic [1:0]  pump_force_mode, abl_code;
  logic [12:0] pump_current_ua, abl_width_ps;
  logic [7:0]  act;       // Active byte
  logic [31:0] r;         // Read bytes
  logic        lsb_m;     // Bit order now in force
  logic        sep_m;     // Separate pin now in force
  int          num_errors, total_checks, cyc;
  assign act = {phase_detector_sense, pump_current_code, pump_force_mode, abl_code};
  scp_top scp_top_inst (.clk, .nrst, .sclk_pin, .cs_n_pin, .sdio_in, .sdio_out, .sdio_oe,
    .serial_out_pin, .serial_out_oe, .update_pin, .separate_output_enable, .lsb_first,
    .phase_detector_sense, .pump_current_code, .pump_force_mode, .abl_code,
    .pump_current_ua, .abl_width_ps);
  scp_host scp_host_inst (.clk, .sdio_out, .sdio_oe, .serial_out_pin, .serial_out_oe,
    .sclk_pin, .cs_n_pin, .sdio_in);
  // Compare and count
  task automatic chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    scp_host_inst.xfer(1'b0, lsb_m, sep_m, a, 1, {24'h0, d}, r);
  endtask
  task automatic rd(input logic [12:0] a, input int n);
    scp_host_inst.xfer(1'b1, lsb_m, sep_m, a, n, 32'h0, r);
  endtask
  // Defaults after reset
  task automatic t_defaults;
    chk(act, 8'h7c);
    chk(pump_current_ua, 13'h12c0);
    chk(abl_width_ps, 13'hb54);
    chk({separate_output_enable, lsb_first}, 2'h0);
    rd(13'h010, 1);
    chk(r[7:0], 8'h7c);
    $display("defaults done");
  endtask
  // Every current, mode and width code through buffer then update
  task automatic t_codes;
    logic [7:0]  b, prev;
    logic [12:0] pst [4];
    pst = '{13'hb54, 13'h514, 13'h1770, 13'hb54};
    prev = 8'h7c;
    for (int k = 0; k < 8; k++) begin
      b = {k[0], k[2:0], k[1:0], k[1:0]};
      wr(13'h010, b);
      rd(13'h010, 1);
      chk(r[7:0], b);
      chk(act, prev);
      update_pin = 1'h1;
      repeat (3) @(negedge clk);
      update_pin = 1'h0;
      repeat (8) @(negedge clk);
      chk(act, b);
      chk(pump_current_ua, ({10'h0, k[2:0]} + 13'h1) * 13'h258);
      chk(abl_width_ps, pst[k[1:0]]);
      prev = b;
    end
    $display("codes done");
  endtask
  // Readback bank select, address stepping down
  task automatic t_select;
    wr(13'h010, 8'h00);
    wr(13'h004, 8'h01);
    rd(13'h010, 1);
    chk(r[7:0], 8'hff);
    rd(13'h005, 2);
    chk(r[15:0], 16'h0100);
    wr(13'h004, 8'h00);
    rd(13'h010, 1);
    chk(r[7:0], 8'h00);
    $display("select done");
  endtask
  // Separate pin, then least significant first with address stepping up
  task automatic t_pins;
    wr(13'h000, 8'h80);
    sep_m = 1'h1;
    chk(separate_output_enable, 1'b1);
    rd(13'h000, 1);
    chk(r[7:0], 8'h81);
    chk(scp_host_inst.bad_q, 1'b0);
    wr(13'h000, 8'h40);
    {sep_m, lsb_m} = 2'h1;
    chk({separate_output_enable, lsb_first}, 2'h1);
    wr(13'h004, 8'h01);
    rd(13'h003, 2);
    chk(r[15:0], 16'h0100);
    chk(scp_host_inst.bad_q, 1'b0);
    $display("pins done");
  endtask
  // Soft reset from least significant first mode
  task automatic t_soft;
    wr(13'h000, 8'h20);
    lsb_m = 1'h0;
    chk({separate_output_enable, lsb_first}, 2'h0);
    chk(act, 8'h7c);
    rd(13'h010, 1);
    chk(r[7:0], 8'h7c);
    rd(13'h000, 1);
    chk(r[7:0], 8'h00);
    rd(13'h004, 1);
    chk(r[7:0], 8'h00);
    $display("soft reset done");
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Hang guard, runs need about 13000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    {nrst, update_pin, lsb_m, sep_m} = 4'h0;
    {num_errors, total_checks, cyc} = '0;
    repeat (4) @(negedge clk);
    nrst = 1;
    repeat (6) @(negedge clk);
    t_defaults();
    t_codes();
    t_select();
    t_pins();
    t_soft();
    results();
  end
endmodule
`default_nettype wire
